// file: rtl/btcm_matcher.sv
// bus trace condition matcher with single-location trace-memory monitor
//
// The register offsets and the strobed register port are this design's own decisions.
module btcm_matcher #(
   parameter int DELAY_W = btcm_pkg::DELAY_W
) (
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire btcm_pkg::btcm_bus_t           bus,
   input  wire logic [btcm_pkg::PROBE_W-1:0]  external_probe_input,
   input  wire logic [3:0]                    reg_addr,
   input  wire logic [31:0]                   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic [31:0]                        reg_rdata,
   output logic                               trigger_out,
   output logic                               parallel_req,
   output logic                               trace_acquire,
   output logic                               reset_notice,
   output logic [7:0]                         reset_notice_code
);
   typedef enum {BTCM_RUN, BTCM_PAR_STOP, BTCM_PAR_LIVE, BTCM_PAUSED} btcm_state_t;

   logic [31:0] ctrl_ff, cond_addr_ff, amask_ff, cond_data_ff, dmask_ff, probe_ff;
   logic [31:0] mon_addr_ff, mon_ctrl_ff;
   logic [DELAY_W-1:0] delay_ff, dcnt_ff;
   logic        dpend_ff;
   logic [31:0] mon_data_ff;
   logic        mon_valid_ff;
   logic        trig_ff, notice_ff, stop_ff;
   btcm_state_t state_ff;

   // write decode
   wire wr_ctrl = reg_wr && reg_addr == btcm_pkg::REG_CTRL;
   wire wr_cmd  = reg_wr && reg_addr == btcm_pkg::REG_CMD;
   wire in_par  = state_ff == BTCM_PAR_STOP || state_ff == BTCM_PAR_LIVE
                  || state_ff == BTCM_PAUSED; // a pause stays inside parallel mode

   // bit-masked equality, masked bits excluded
   function automatic logic masked_eq(input logic [31:0] a, input logic [31:0] b, input logic [31:0] m);
      masked_eq = ((a ^ b) & ~m) == 32'h0000_0000;
   endfunction

   // condition registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= btcm_pkg::CTRL_RESET;
         cond_addr_ff <= 32'h0;
         amask_ff <= 32'h0;
         cond_data_ff <= 32'h0;
         dmask_ff <= 32'h0;
         probe_ff <= 32'h0;
         delay_ff <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            btcm_pkg::REG_CTRL:  ctrl_ff <= reg_wdata;
            btcm_pkg::REG_ADDR:  cond_addr_ff <= reg_wdata;
            btcm_pkg::REG_AMASK: amask_ff <= reg_wdata;
            btcm_pkg::REG_DATA:  cond_data_ff <= reg_wdata;
            btcm_pkg::REG_DMASK: dmask_ff <= reg_wdata;
            btcm_pkg::REG_PROBE: probe_ff <= reg_wdata;
            btcm_pkg::REG_DELAY: delay_ff <= reg_wdata[DELAY_W-1:0];
            default: ;
         endcase
      end
   end

   // decoded control fields
   wire        c_ena   = ctrl_ff[btcm_pkg::CTRL_ENA];
   wire        c_stop  = ctrl_ff[btcm_pkg::CTRL_MODE];
   wire        c_aen   = ctrl_ff[btcm_pkg::CTRL_ADDR_EN];
   wire        c_den   = ctrl_ff[btcm_pkg::CTRL_DATA_EN];
   wire        c_pen   = ctrl_ff[btcm_pkg::CTRL_PROBE_EN];
   wire [1:0]  c_type  = ctrl_ff[btcm_pkg::CTRL_TYPE_LO +: 2];
   wire [1:0]  c_size  = ctrl_ff[btcm_pkg::CTRL_SIZE_LO +: 2];
   wire [1:0]  c_area  = ctrl_ff[btcm_pkg::CTRL_AREA_LO +: 2];
   wire [1:0]  c_rw    = ctrl_ff[btcm_pkg::CTRL_RW_LO +: 2];

   // pc-relative reads classified as fetch cycles
   wire [1:0] eff_kind = bus.pc_rel ? btcm_pkg::BTCM_TY_FETCH : bus.kind;
   wire       type_ok  = c_type == btcm_pkg::BTCM_TY_ALL || c_type == eff_kind;
   wire       rw_ok    = c_rw == 2'h0 || (c_rw == 2'h1 && !bus.write) || (c_rw == 2'h2 && bus.write);

   // address match uses full width under mask
   wire addr_hit = masked_eq(bus.addr, cond_addr_ff, amask_ff);
   wire addr_free = !c_aen || amask_ff == 32'hffff_ffff;

   // data value as seen on the lanes for the area and size
   logic [31:0] dval, dmask_eff;
   logic        size_ok, align_ok;
   always_comb begin
      dval = bus.data;
      dmask_eff = dmask_ff;
      size_ok = 1'b1;
      align_ok = 1'b1;
      case (c_area)
         btcm_pkg::BTCM_AREA_32: begin
            if (c_size == btcm_pkg::BTCM_SZ_LONG) align_ok = bus.addr[1:0] == 2'h0;
            else if (c_size == btcm_pkg::BTCM_SZ_WORD) begin
               align_ok = !bus.addr[0];
               dmask_eff = dmask_ff | 32'hffff_0000;
            end else dmask_eff = dmask_ff | 32'hffff_ff00;
            if (c_size != btcm_pkg::BTCM_SZ_LONG && addr_free)
               align_ok = bus.addr[1:0] == 2'h0;
         end
         btcm_pkg::BTCM_AREA_16: begin
            if (c_size == btcm_pkg::BTCM_SZ_BYTE) begin
               dmask_eff = dmask_ff | 32'hffff_ff00;
               if (addr_free) align_ok = !bus.addr[0];
            end else begin
               align_ok = !bus.addr[0];
               dmask_eff = dmask_ff | 32'hffff_0000; // long arrives as word halves
               if (c_size == btcm_pkg::BTCM_SZ_LONG)
                  dval = {16'h0, bus.addr[1] ? bus.data[15:0] : bus.data[15:0]};
               if (c_size == btcm_pkg::BTCM_SZ_LONG && bus.addr[1])
                  dval = {16'h0, bus.data[15:0]};
            end
         end
         default: begin
            size_ok = c_size == btcm_pkg::BTCM_SZ_BYTE;
            dmask_eff = dmask_ff | 32'hffff_ff00;
         end
      endcase
   end

   // long condition in 16-bit area compares the matching half
   wire [31:0] dcond = (c_area == btcm_pkg::BTCM_AREA_16 && c_size == btcm_pkg::BTCM_SZ_LONG)
                       ? {16'h0, bus.addr[1] ? cond_data_ff[15:0] : cond_data_ff[31:16]} : cond_data_ff;
   wire data_hit  = size_ok && align_ok && masked_eq(dval, dcond, dmask_eff);
   wire [31:0] probe_mask = {{(32-btcm_pkg::PROBE_W){1'b0}}, probe_ff[btcm_pkg::PROBE_MASK_LO +: btcm_pkg::PROBE_W]};
   wire probe_hit = masked_eq({{(32-btcm_pkg::PROBE_W){1'b0}}, external_probe_input},
                              {{(32-btcm_pkg::PROBE_W){1'b0}}, probe_ff[btcm_pkg::PROBE_W-1:0]},
                              probe_mask);
   wire addr_ok   = !c_aen || addr_hit && (c_den || align_ok || c_area == btcm_pkg::BTCM_AREA_8);

   // conditions are live only while running or in space-key parallel mode
   wire active = c_ena && (state_ff == BTCM_RUN || state_ff == BTCM_PAR_LIVE);
   wire raw_hit = active && bus.valid && type_ok && rw_ok && addr_ok
                  && (!c_den || data_hit) && (!c_pen || probe_hit);

   // delay counting after the other conditions match
   // a pending delay must not complete once conditions go inactive
   wire delay_done = active && dpend_ff && bus.valid && dcnt_ff == DELAY_W'(1);
   wire full_hit = (delay_ff == '0) ? raw_hit : delay_done;
   // restart only on the transitions that really reactivate the conditions
   wire restart = wr_cmd && ((state_ff == BTCM_PAR_STOP && reg_wdata[btcm_pkg::CMD_PAR_EXIT])
                  || (state_ff == BTCM_PAUSED && reg_wdata[btcm_pkg::CMD_RESUME]));

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dpend_ff <= 1'b0;
         dcnt_ff <= '0;
      end else if (restart || wr_ctrl || !active) begin
         dpend_ff <= 1'b0;
         dcnt_ff <= '0;
      end else if (!dpend_ff && raw_hit && delay_ff != '0) begin
         dpend_ff <= 1'b1;
         dcnt_ff <= delay_ff;
      end else if (dpend_ff && bus.valid) begin
         dcnt_ff <= dcnt_ff - DELAY_W'(1);
         if (dcnt_ff == DELAY_W'(1)) dpend_ff <= 1'b0;
      end
   end

   // mode state: parallel entry, pause and exit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= BTCM_RUN;
      end else begin
         case (state_ff)
            BTCM_RUN: begin
               if (full_hit && c_stop) state_ff <= BTCM_PAR_STOP;
               else if (wr_cmd && reg_wdata[btcm_pkg::CMD_PAR_RET]) state_ff <= BTCM_PAR_STOP;
               else if (wr_cmd && reg_wdata[btcm_pkg::CMD_PAR_SPACE]) state_ff <= BTCM_PAR_LIVE;
            end
            BTCM_PAR_STOP: if (wr_cmd && reg_wdata[btcm_pkg::CMD_PAR_EXIT]) state_ff <= BTCM_RUN;
            BTCM_PAR_LIVE: begin
               if (full_hit && c_stop) state_ff <= BTCM_PAR_STOP;
               else if (wr_cmd && reg_wdata[btcm_pkg::CMD_PAUSE]) state_ff <= BTCM_PAUSED;
               else if (wr_cmd && reg_wdata[btcm_pkg::CMD_PAR_EXIT]) state_ff <= BTCM_RUN;
            end
            BTCM_PAUSED: if (wr_cmd && reg_wdata[btcm_pkg::CMD_RESUME]) state_ff <= BTCM_PAR_LIVE;
            default: state_ff <= BTCM_RUN;
         endcase
      end
   end

   // trigger pulse, stop request and reset notice
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         trig_ff <= 1'b0;
         stop_ff <= 1'b0;
         notice_ff <= 1'b0;
      end else begin
         trig_ff <= full_hit && !c_stop;
         stop_ff <= full_hit && c_stop && state_ff != BTCM_PAR_STOP;
         notice_ff <= restart;
      end
   end

   assign trigger_out = trig_ff;
   assign parallel_req = stop_ff;
   assign reset_notice = notice_ff;
   assign reset_notice_code = btcm_pkg::RESET_NOTICE;
   assign trace_acquire = active && bus.valid && !restart;

   // monitor configuration; removal refused in parallel mode
   wire mon_clear = wr_cmd && reg_wdata[btcm_pkg::CMD_MON_CLEAR];
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mon_addr_ff <= 32'h0;
         mon_ctrl_ff <= btcm_pkg::MON_CTRL_RESET;
      end else begin
         if (reg_wr && reg_addr == btcm_pkg::REG_MON_ADDR) mon_addr_ff <= reg_wdata;
         if (reg_wr && reg_addr == btcm_pkg::REG_MON_CTRL) begin
            if (in_par && !reg_wdata[btcm_pkg::MON_EN])
               mon_ctrl_ff <= {reg_wdata[31:1], 1'b1};
            else mon_ctrl_ff <= reg_wdata;
         end else if (mon_clear && !in_par) mon_ctrl_ff[btcm_pkg::MON_EN] <= 1'b0;
      end
   end

   // monitor capture: A0 ignored, A1 compared, real accesses only
   wire [1:0] mon_size = mon_ctrl_ff[btcm_pkg::MON_SIZE_LO +: 2];
   wire mon_kind_ok = mon_ctrl_ff[btcm_pkg::MON_DMA] ? bus.kind == btcm_pkg::BTCM_TY_DMA
                                                     : bus.kind == btcm_pkg::BTCM_TY_EXEC;
   wire mon_hit = mon_ctrl_ff[btcm_pkg::MON_EN] && bus.valid && mon_kind_ok && !bus.pc_rel
                  && bus.addr[31:1] == mon_addr_ff[31:1];
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mon_data_ff <= 32'h0;
         mon_valid_ff <= 1'b0;
      end else if (mon_hit) begin // old value held until new address accessed
         mon_valid_ff <= 1'b1;
         case (mon_size)
            2'h0: mon_data_ff <= {24'h0, bus.data[7:0]};
            2'h1: mon_data_ff <= {16'h0, bus.data[15:0]};
            default: mon_data_ff <= bus.data;
         endcase
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) reg_rdata <= 32'h0;
      else if (reg_rd) begin
         case (reg_addr)
            btcm_pkg::REG_CTRL:     reg_rdata <= ctrl_ff;
            btcm_pkg::REG_ADDR:     reg_rdata <= cond_addr_ff;
            btcm_pkg::REG_AMASK:    reg_rdata <= amask_ff;
            btcm_pkg::REG_DATA:     reg_rdata <= cond_data_ff;
            btcm_pkg::REG_DMASK:    reg_rdata <= dmask_ff;
            btcm_pkg::REG_PROBE:    reg_rdata <= probe_ff;
            btcm_pkg::REG_DELAY:    reg_rdata <= {{(32-DELAY_W){1'b0}}, delay_ff};
            btcm_pkg::REG_MON_ADDR: reg_rdata <= mon_addr_ff;
            btcm_pkg::REG_MON_CTRL: reg_rdata <= mon_ctrl_ff;
            btcm_pkg::REG_MON_DATA: reg_rdata <= mon_data_ff;
            btcm_pkg::REG_STATUS:   reg_rdata <= {27'h0, mon_valid_ff, dpend_ff, in_par,
                                                  state_ff == BTCM_PAUSED, active};
            default:                reg_rdata <= 32'h0;
         endcase
      end else reg_rdata <= 32'h0;
   end

   // trigger pulse lasts one cycle
   trig_pulse_a: assert property (@(posedge clk) disable iff (!rst_b) trigger_out |=> !trigger_out)
      else $error("trigger longer than one cycle");
   // trigger follows a full trigger-mode hit
   trig_cause_a: assert property (@(posedge clk) disable iff (!rst_b) full_hit && !c_stop |=> trigger_out)
      else $error("trigger missing after hit");
   // no acquisition in stop-type parallel mode
   par_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
      state_ff == BTCM_PAR_STOP |-> !trace_acquire ##1 !trigger_out)
      else $error("acquiring in stopped parallel mode");
   // notice raised after restart
   sequence exit_seq; restart; endsequence
   notice_a: assert property (@(posedge clk) disable iff (!rst_b) exit_seq |=> reset_notice && !dpend_ff)
      else $error("no reset notice on restart");
   // stop hit enters parallel mode
   stop_par_a: assert property (@(posedge clk) disable iff (!rst_b)
      full_hit && c_stop && state_ff == BTCM_RUN |=> state_ff == BTCM_PAR_STOP && parallel_req)
      else $error("stop hit did not enter parallel");
   // monitor ignores pc-relative reads
   mon_pcrel_a: assert property (@(posedge clk) disable iff (!rst_b)
      bus.valid && bus.pc_rel |=> $stable(mon_data_ff))
      else $error("monitor updated on pc-relative read");
   // monitor ignores A1 mismatch
   mon_a1_a: assert property (@(posedge clk) disable iff (!rst_b)
      bus.valid && bus.addr[1] != mon_addr_ff[1] |=> $stable(mon_data_ff))
      else $error("monitor updated on A1 mismatch");
   // watch stays enabled during parallel mode
   mon_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
      in_par && mon_ctrl_ff[btcm_pkg::MON_EN] |=> mon_ctrl_ff[btcm_pkg::MON_EN])
      else $error("watch removed in parallel mode");
   // fetch condition accepts pc-relative reads
   fetch_pc_a: assert property (@(posedge clk) disable iff (!rst_b)
      c_type == btcm_pkg::BTCM_TY_FETCH && bus.pc_rel |-> type_ok)
      else $error("pc-relative read not a fetch");
endmodule

// file: common/btcm_pkg.sv
// package for the bus trace condition matcher: constants and carriers
package btcm_pkg;
   localparam int         ADDR_W = 32;
   localparam int         DATA_W = 32;
   localparam int         PROBE_W = 4;
   localparam int         PROBE_MASK_LO = 16; // probe mask field in the probe register
   localparam int         DELAY_W = 15;
   localparam logic [14:0] DELAY_MAX = 15'h7fff;
   localparam logic [7:0] RESET_NOTICE = 8'h81;
   // register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_AMASK = 4'h2;
   localparam logic [3:0] REG_DATA = 4'h3;
   localparam logic [3:0] REG_DMASK = 4'h4;
   localparam logic [3:0] REG_PROBE = 4'h5;
   localparam logic [3:0] REG_DELAY = 4'h6;
   localparam logic [3:0] REG_MON_ADDR = 4'h7;
   localparam logic [3:0] REG_MON_CTRL = 4'h8;
   localparam logic [3:0] REG_MON_DATA = 4'h9;
   localparam logic [3:0] REG_STATUS = 4'ha;
   localparam logic [3:0] REG_CMD = 4'hb;
   // control field positions
   localparam int CTRL_ENA = 0;
   localparam int CTRL_MODE = 1;   // 0 trigger, 1 trace stop
   localparam int CTRL_ADDR_EN = 2;
   localparam int CTRL_DATA_EN = 3;
   localparam int CTRL_PROBE_EN = 4;
   localparam int CTRL_TYPE_LO = 5; // 2 bits
   localparam int CTRL_SIZE_LO = 7; // 2 bits data size
   localparam int CTRL_AREA_LO = 9; // 2 bits bus area width
   localparam int CTRL_RW_LO = 11; // 2 bits: 0 any,1 read,2 write
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // command bits
   localparam int CMD_PAR_RET = 0;
   localparam int CMD_PAR_SPACE = 1;
   localparam int CMD_PAR_EXIT = 2;
   localparam int CMD_PAUSE = 3;
   localparam int CMD_RESUME = 4;
   localparam int CMD_MON_CLEAR = 5;
   // monitor control
   localparam int MON_EN = 0;
   localparam int MON_DMA = 1;
   localparam int MON_SIZE_LO = 2;
   localparam logic [31:0] MON_CTRL_RESET = 32'h0000_0004; // 16-bit, execution

   typedef enum logic [1:0] {BTCM_SZ_BYTE = 2'h0, BTCM_SZ_WORD = 2'h1, BTCM_SZ_LONG = 2'h2} btcm_size_t;
   typedef enum logic [1:0] {BTCM_TY_ALL = 2'h0, BTCM_TY_FETCH = 2'h1, BTCM_TY_EXEC = 2'h2, BTCM_TY_DMA = 2'h3} btcm_type_t;
   typedef enum logic [1:0] {BTCM_AREA_8 = 2'h0, BTCM_AREA_16 = 2'h1, BTCM_AREA_32 = 2'h2} btcm_area_t;

   // one observed bus cycle
   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic              write;
      logic [1:0]        kind;   // cycle kind: fetch, exec, dma
      logic              pc_rel; // pc-relative data read
   } btcm_bus_t;
endpackage

// file: tb/btcm_bus_model.sv
// target bus model: turns each request into one observed bus cycle
module btcm_bus_model (
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                go,
   input  wire btcm_pkg::btcm_bus_t req,
   output btcm_pkg::btcm_bus_t      bus
);
   timeunit 1ns;
   timeprecision 1ns;
   // one valid cycle per request; idle address and data lines toggle so stale values never match by chance
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bus <= '0;
      end else if (go) begin
         bus <= req;
      end else begin
         bus.valid <= 1'b0;
         bus.addr  <= ~bus.addr;
         bus.data  <= ~bus.data;
      end
   end
endmodule

// file: tb/testbench.sv
// self-checking bench for the bus trace condition matcher
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                clk, rst_b, go, reg_wr, reg_rd;
   logic                trigger_out, parallel_req, trace_acquire, reset_notice;
   btcm_pkg::btcm_bus_t req, bus;
   logic [3:0]          probe, reg_addr;
   logic [31:0]         reg_wdata, reg_rdata, v;
   logic [7:0]          code;
   int                  n_errors = 0, total_checks = 0, n_trig = 0, n_par = 0, n_rst = 0, n_cyc = 0;

   btcm_matcher dut_u (.clk(clk), .rst_b(rst_b), .bus(bus), .external_probe_input(probe),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .trigger_out(trigger_out), .parallel_req(parallel_req), .trace_acquire(trace_acquire),
      .reset_notice(reset_notice), .reset_notice_code(code));
   btcm_bus_model model_u (.clk(clk), .rst_b(rst_b), .go(go), .req(req), .bus(bus));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // pulse counters and hang guard
   always @(posedge clk) begin
      n_cyc++;
      if (trigger_out === 1'b1) n_trig++;
      if (parallel_req === 1'b1) n_par++;
      if (reset_notice === 1'b1) n_rst++;
      if (n_cyc == 5000) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (n_errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // one bus cycle; returns while it stands on the bus
   task automatic cyc(logic [31:0] a, logic [31:0] d, logic [1:0] k = 2'h2, logic p = 1'b0);
      @(posedge clk);
      go  <= 1'b1;
      req <= '{valid: 1'b1, addr: a, data: d, write: 1'b0, kind: k, pc_rel: p};
      @(posedge clk);
      go <= 1'b0;
      #1;
   endtask

   task automatic settle();
      repeat (4) @(posedge clk);
   endtask

   function automatic logic [31:0] cfg(logic m, logic [2:0] en, logic [1:0] ty, logic [1:0] sz, logic [1:0] ar);
      cfg = 32'h1 | (32'(m) << btcm_pkg::CTRL_MODE) | (32'(en) << btcm_pkg::CTRL_ADDR_EN)
          | (32'(ty) << btcm_pkg::CTRL_TYPE_LO) | (32'(sz) << btcm_pkg::CTRL_SIZE_LO)
          | (32'(ar) << btcm_pkg::CTRL_AREA_LO);
   endfunction

   task automatic cond(logic [31:0] a, logic [31:0] am, logic [31:0] d, logic [31:0] c);
      wr(btcm_pkg::REG_ADDR, a);
      wr(btcm_pkg::REG_AMASK, am);
      wr(btcm_pkg::REG_DATA, d);
      wr(btcm_pkg::REG_DMASK, 32'h0);
      wr(btcm_pkg::REG_CTRL, c);
   endtask

   task automatic t_reset();
      rd(btcm_pkg::REG_MON_CTRL, v);
      chk("mon ctrl reset", 32'h4, v);
      rd(btcm_pkg::REG_CTRL, v);
      chk("ctrl reset", 32'h0, v);
      rd(4'hc, v);
      chk("unmapped read", 32'h0, v);
   endtask

   task automatic t_sizes();
      int t;
      t = n_trig;
      cond(32'h1000, 32'h0, 32'hdeadbeef, cfg(0, 3'h3, 2'h0, 2'h2, 2'h2));
      cyc(32'h1000, 32'hdeadbeef);
      cyc(32'h1000, 32'hdeadbeee);
      cyc(32'h1004, 32'hdeadbeef);
      settle();
      chk("long 32 trig", 1, n_trig - t);
      cond(32'h1002, 32'h0, 32'h12341234, cfg(0, 3'h3, 2'h0, 2'h1, 2'h2));
      cyc(32'h1002, 32'h12341234);
      cond(32'h800, 32'h0, 32'haabbccdd, cfg(0, 3'h3, 2'h0, 2'h2, 2'h1));
      cyc(32'h800, 32'haabbaabb);
      cyc(32'h802, 32'hccddccdd);
      cond(32'h0, 32'hffffffff, 32'h5a5a5a5a, cfg(0, 3'h2, 2'h0, 2'h0, 2'h1));
      cyc(32'h201, 32'h5a5a5a5a);
      cyc(32'h200, 32'h5a5a5a5a);
      cond(32'h0, 32'hffffffff, 32'h12341234, cfg(0, 3'h2, 2'h0, 2'h1, 2'h2));
      cyc(32'h202, 32'h12341234);
      cyc(32'h204, 32'h12341234);
      cond(32'h301, 32'h0, 32'h5a5a5a5a, cfg(0, 3'h3, 2'h0, 2'h0, 2'h0));
      cyc(32'h301, 32'h5a5a5a5a);
      settle();
      chk("area size trig", 6, n_trig - t);
   endtask

   task automatic t_mask();
      int t;
      cond(32'h0600_0010, 32'h0, 32'h0, cfg(0, 3'h1, 2'h0, 2'h2, 2'h2));
      t = n_trig;
      cyc(32'h2600_0010, 32'h0);
      settle();
      chk("alias trig", 0, n_trig - t);
      wr(btcm_pkg::REG_AMASK, 32'hf000_0000);
      cyc(32'h2600_0010, 32'h0);
      wr(btcm_pkg::REG_AMASK, 32'h0000_00ff);
      cyc(32'h0600_00ac, 32'h0);
      wr(btcm_pkg::REG_PROBE, 32'h0002_0005);
      wr(btcm_pkg::REG_CTRL, cfg(0, 3'h4, 2'h0, 2'h2, 2'h2));
      @(posedge clk);
      probe <= 4'h6;
      cyc(32'h0, 32'h0);
      @(posedge clk);
      probe <= 4'h7;
      cyc(32'h0, 32'h0);
      settle();
      chk("masked trig", 3, n_trig - t);
   endtask

   task automatic t_type();
      int t;
      for (int ty = 0; ty < 4; ty++) begin
         cond(32'h400, 32'h0, 32'h0, cfg(0, 3'h1, 2'(ty), 2'h2, 2'h2));
         t = n_trig;
         for (int k = 1; k < 4; k++) cyc(32'h400, 32'h0, 2'(k));
         settle();
         chk("type trig", (ty == 0) ? 3 : 1, n_trig - t);
      end
      wr(btcm_pkg::REG_CTRL, cfg(0, 3'h1, 2'h1, 2'h2, 2'h2));
      t = n_trig;
      cyc(32'h400, 32'h0, 2'h2, 1'b1);
      settle();
      chk("pc rel as fetch", 1, n_trig - t);
      t = n_trig;
      wr(btcm_pkg::REG_CTRL, cfg(0, 3'h1, 2'h0, 2'h2, 2'h2) | (32'h2 << btcm_pkg::CTRL_RW_LO));
      cyc(32'h400, 32'h0);
      wr(btcm_pkg::REG_CTRL, cfg(0, 3'h1, 2'h0, 2'h2, 2'h2) | (32'h1 << btcm_pkg::CTRL_RW_LO));
      cyc(32'h400, 32'h0);
      settle();
      chk("read write cond", 1, n_trig - t);
   endtask

   task automatic t_delay();
      int t;
      cond(32'h500, 32'h0, 32'h0, cfg(0, 3'h1, 2'h0, 2'h2, 2'h2));
      wr(btcm_pkg::REG_DELAY, 32'h3);
      t = n_trig;
      cyc(32'h500, 32'h0);
      cyc(32'h504, 32'h0);
      cyc(32'h504, 32'h0);
      repeat (2) @(posedge clk);
      chk("delay early", 0, n_trig - t);
      cyc(32'h504, 32'h0);
      settle();
      chk("delay due", 1, n_trig - t);
      wr(btcm_pkg::REG_DELAY, 32'h0);
   endtask

   task automatic t_stop();
      int p;
      int r;
      p = n_par;
      r = n_rst;
      cond(32'h600, 32'h0, 32'h0, cfg(1, 3'h1, 2'h0, 2'h2, 2'h2));
      cyc(32'h600, 32'h0);
      settle();
      chk("stop request", 1, n_par - p);
      cyc(32'h600, 32'h0);
      chk("acquire in stop", 0, trace_acquire);
      settle();
      chk("no restop", 1, n_par - p);
      rd(btcm_pkg::REG_STATUS, v);
      chk("status stopped", 32'h4, v);
      wr(btcm_pkg::REG_CMD, 32'h1 << btcm_pkg::CMD_PAR_EXIT);
      settle();
      chk("restart notice", 1, n_rst - r);
      chk("notice code", 8'h81, code);
      cyc(32'h604, 32'h0);
      chk("acquire resumed", 1, trace_acquire);
      wr(btcm_pkg::REG_CMD, 32'h1 << btcm_pkg::CMD_PAR_SPACE);
      cyc(32'h604, 32'h0);
      chk("acquire space", 1, trace_acquire);
      wr(btcm_pkg::REG_CMD, 32'h1 << btcm_pkg::CMD_PAUSE);
      cyc(32'h604, 32'h0);
      chk("acquire paused", 0, trace_acquire);
      rd(btcm_pkg::REG_STATUS, v);
      chk("status paused", 32'h6, v);
      wr(btcm_pkg::REG_CMD, 32'h1 << btcm_pkg::CMD_RESUME);
      settle();
      chk("resume notice", 2, n_rst - r);
      wr(btcm_pkg::REG_CMD, 32'h1 << btcm_pkg::CMD_PAR_EXIT);
      wr(btcm_pkg::REG_CTRL, 32'h0);
   endtask

   task automatic t_mon();
      wr(btcm_pkg::REG_MON_ADDR, 32'h100);
      wr(btcm_pkg::REG_MON_CTRL, 32'h9);
      cyc(32'h101, 32'ha5a5a5a5);
      rd(btcm_pkg::REG_MON_DATA, v);
      chk("mon capture", 32'ha5a5a5a5, v);
      cyc(32'h102, 32'h1);
      cyc(32'h100, 32'h2, 2'h2, 1'b1);
      cyc(32'h100, 32'h3, 2'h3);
      rd(btcm_pkg::REG_MON_DATA, v);
      chk("mon kept", 32'ha5a5a5a5, v);
      wr(btcm_pkg::REG_MON_CTRL, 32'h3);
      cyc(32'h100, 32'h11223344, 2'h3);
      rd(btcm_pkg::REG_MON_DATA, v);
      chk("mon dma byte", 32'h44, v);
      wr(btcm_pkg::REG_CMD, 32'h1 << btcm_pkg::CMD_PAR_RET);
      wr(btcm_pkg::REG_CMD, 32'h1 << btcm_pkg::CMD_MON_CLEAR);
      wr(btcm_pkg::REG_MON_CTRL, 32'h2);
      rd(btcm_pkg::REG_MON_CTRL, v);
      chk("mon removal", 32'h3, v);
      wr(btcm_pkg::REG_MON_ADDR, 32'h200);
      rd(btcm_pkg::REG_MON_DATA, v);
      chk("mon old value", 32'h44, v);
      cyc(32'h200, 32'h77, 2'h3);
      rd(btcm_pkg::REG_MON_DATA, v);
      chk("mon new value", 32'h77, v);
      wr(btcm_pkg::REG_CMD, 32'h1 << btcm_pkg::CMD_PAR_EXIT);
      wr(btcm_pkg::REG_CMD, 32'h1 << btcm_pkg::CMD_MON_CLEAR);
      rd(btcm_pkg::REG_MON_CTRL, v);
      chk("mon clear outside parallel", 32'h2, v);
   endtask

   // reset, then the scenarios in turn
   initial begin
      rst_b     = 1'b0;
      go        = 1'b0;
      req       = '0;
      probe     = 4'h0;
      reg_addr  = 4'h0;
      reg_wdata = 32'h0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_sizes();
      t_mask();
      t_type();
      t_delay();
      t_stop();
      t_mon();
      print_verdict();
   end
endmodule
